// [sensor_cfg_consts.svh]
// Purpose: offsets, field positions, reset values and timing counts of the config array
// Assumes: 5-bit register address, 8-bit registers, 16-bit serial frames
// Notes: included by the package and the register array
`ifndef SENSOR_CFG_CONSTS_SVH
`define SENSOR_CFG_CONSTS_SVH

// register offsets
`define OFS_UNIT_ID0 5'h00
`define OFS_UNIT_ID1 5'h01
`define OFS_UNIT_ID2 5'h02
`define OFS_UNIT_ID3 5'h03
`define OFS_SELF_TEST_DEFL 5'h04
`define OFS_RESERVED_05 5'h05
`define OFS_FACTORY_CONFIG 5'h06
`define OFS_PART_NUMBER 5'h08
`define OFS_DEVICE_CONTROL 5'h0A
`define OFS_DEVICE_CONFIG 5'h0B
`define OFS_AXIS_CONFIG 5'h0C
`define OFS_ARMING_CONFIG 5'h0E
`define OFS_ARM_THR_POS 5'h10
`define OFS_ARM_THR_NEG 5'h12
`define OFS_DEVICE_STATUS 5'h14
`define OFS_ARM_TALLY 5'h15
`define OFS_OFFSET_CORR 5'h16
`define OFS_RESERVED_1C 5'h1C
`define OFS_RESERVED_1D 5'h1D

// field positions
`define CTL_KEY_HI 7
`define CTL_KEY_LO 6
`define CTL_OFFCFG_EN 3
`define CFG_OC_N 7
`define CFG_ENDINIT 5
`define CFG_OFMON 3
`define AXIS_ST 7
`define STAT_IDE 6
`define STAT_DEVINIT 4
`define STAT_MISOERR 3
`define STAT_OFFSET 1
`define STAT_DEVRES 0
`define UNIT_SERIAL_BITS 13

// reset values
`define RST_REG8 8'h00
`define RST_CTL_LOW 6'h00
`define RST_CRC 8'h00

// frame layout and answer codes
`define FRAME_BITS 5'h10
`define RESP_OK 3'h1
`define RESP_INVALID 3'h7
`define CRC_POLY 8'h2F

// timing
`define CLK_PERIOD_NS 50
`define CLK_FREQ_KHZ 20000
`define TEST_FREQ_KHZ 1000
`define TEST_HALF_CYCLES (`CLK_FREQ_KHZ / `TEST_FREQ_KHZ / 2)
`define T_SPI_RESET_NS 300
`define SPI_RESET_MAX_CYCLES (`T_SPI_RESET_NS / `CLK_PERIOD_NS)
`define T_POR_READY_US 840
`define POR_READY_CYCLES (`T_POR_READY_US * 1000 / `CLK_PERIOD_NS)

`endif

// [sensor_cfg_pkg.sv]
// Purpose: shared types of the config array
// Assumes: constants come from sensor_cfg_consts.svh
// Notes: frames are msb first
`include "sensor_cfg_consts.svh"

package sensor_cfg_pkg;

	typedef struct packed {
		logic write;
		logic [1:0] spare;
		logic [4:0] addr;
		logic [7:0] data;
	} cmd_t;

	typedef struct packed {
		logic [2:0] status;
		logic [4:0] addr;
		logic [7:0] data;
	} resp_t;

	typedef struct packed {
		logic [7:0] device_config;
		logic [7:0] axis_config;
		logic [7:0] arming_config;
		logic [7:0] arming_threshold_pos;
		logic [7:0] arming_threshold_neg;
	} cfg_t;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_FIRST,
		KEY_SECOND
	} reset_key_t;

endpackage

// [sensor_config_data_array.sv]
// Purpose: customer register array behind a four-wire serial port
// Assumes: SCLK mode 0, 16-bit frames, answer returned in the following frame
// Notes: the serial input pins are oversampled by CLK; serial clock must stay well below CLK/4
`include "sensor_cfg_consts.svh"

module sensor_config_data_array #(
	parameter logic [18:0] LOT_NUMBER = 19'h00001,
	parameter logic [12:0] SERIAL_NUMBER = 13'h0001,
	parameter logic [7:0] SELF_TEST_DEFL = 8'h80,
	parameter logic [7:0] FACTORY_TRIM_05 = 8'h00,
	parameter logic SELF_TEST_MAG = 1'b1,
	parameter logic [7:0] PART_NUMBER = 8'h00,
	parameter logic [7:0] FACTORY_TRIM_1C = 8'h00,
	parameter logic [7:0] FACTORY_TRIM_1D = 8'h00,
	parameter int POR_READY_CYCLES = `POR_READY_CYCLES
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic MOSI,
	output logic MISO,
	output logic MISO_OE,
	input wire logic [7:0] ARM_TALLY,
	input wire logic [7:0] OFFSET_CORR,
	input wire logic MISO_ERR,
	input wire logic OFFSET_ERR,
	output sensor_cfg_pkg::cfg_t CFG,
	output logic [5:0] CTL_LOW,
	output logic OFFSET_MONITOR_EN,
	output logic SELF_TEST_EN,
	output logic CRC_ERR,
	output logic SOFT_RESET,
	output logic READY,
	output logic TEST_CLK
);
	import sensor_cfg_pkg::*;

	function automatic logic [7:0] crc8(input logic [71:0] bytes);
		logic [7:0] c;
		c = `RST_CRC;
		for (int i = 71; i >= 0; i--) begin
			c = (c[7] ^ bytes[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	// unit identifier built from lot and serial number
	localparam logic [31:0] UNIT_ID = {LOT_NUMBER, SERIAL_NUMBER};
	localparam logic [7:0] FACTORY_CONFIG = {SELF_TEST_MAG, 7'h00};
	localparam logic [71:0] OTP_IMAGE = {UNIT_ID, SELF_TEST_DEFL, FACTORY_TRIM_05,
		FACTORY_CONFIG, PART_NUMBER, FACTORY_TRIM_1C};
	// golden factory checksum including the identifier bytes
	localparam logic [7:0] OTP_CRC_REF = crc8(OTP_IMAGE);

	// pin synchronisers
	logic [2:0] cs_sync;
	logic [2:0] sclk_sync;
	logic [1:0] mosi_sync;
	logic [4:0] bit_cnt;
	logic [15:0] rx_shift;
	logic [15:0] tx_shift;
	// factory shadow, only faults can disturb it
	logic [71:0] otp_shadow;
	logic [7:0] trim_1d;
	logic [5:0] ctl_low;
	logic [7:0] device_config;
	logic [7:0] axis_config;
	logic [7:0] arming_config;
	logic [7:0] thr_pos;
	logic [7:0] thr_neg;
	logic [7:0] wcrc_ref;
	logic wcrc_armed;
	logic devres;
	logic soft_rst;
	reset_key_t key_state;
	reset_key_t next_key_state;
	resp_t resp;
	logic [19:0] por_cnt;
	logic [7:0] test_cnt;
	logic test_clk;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cs_sync <= 3'h7;
			sclk_sync <= 3'h0;
			mosi_sync <= 2'h0;
		end else begin
			cs_sync <= {cs_sync[1:0], CS_N};
			sclk_sync <= {sclk_sync[1:0], SCLK};
			mosi_sync <= {mosi_sync[0], MOSI};
		end
	end

	// edges use stages 2 and 3 only; stage 1 feeds stage 2 alone
	wire cs_low = ~cs_sync[1];
	wire cs_fall = ~cs_sync[1] & cs_sync[2];
	wire cs_rise = cs_sync[1] & ~cs_sync[2];
	wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
	wire sclk_fall = ~sclk_sync[1] & sclk_sync[2];
	wire frame_done = cs_rise & (bit_cnt == `FRAME_BITS);
	// short or long frames are dropped whole
	wire frame_bad = cs_rise & (bit_cnt != `FRAME_BITS);

	wire cmd_t cmd = rx_shift;
	wire wr = frame_done & cmd.write;
	wire rd = frame_done & ~cmd.write;
	wire endinit = device_config[`CFG_ENDINIT];
	wire unlocked = ~endinit;

	// address decode
	wire hit_ctl = cmd.addr == `OFS_DEVICE_CONTROL;
	wire hit_cfg = cmd.addr == `OFS_DEVICE_CONFIG;
	wire hit_axis = cmd.addr == `OFS_AXIS_CONFIG;
	wire hit_arm = cmd.addr == `OFS_ARMING_CONFIG;
	wire hit_pos = cmd.addr == `OFS_ARM_THR_POS;
	wire hit_neg = cmd.addr == `OFS_ARM_THR_NEG;
	wire hit_stat = cmd.addr == `OFS_DEVICE_STATUS;
	wire hit_factory = cmd.addr <= `OFS_FACTORY_CONFIG || cmd.addr == `OFS_PART_NUMBER;
	wire hit_ro = hit_stat || cmd.addr == `OFS_ARM_TALLY || cmd.addr == `OFS_OFFSET_CORR;
	wire hit_rsv = cmd.addr == `OFS_RESERVED_1C || cmd.addr == `OFS_RESERVED_1D;
	wire hit_rw = hit_ctl | hit_cfg | hit_axis | hit_arm | hit_pos | hit_neg;
	wire hit_valid = hit_factory | hit_ro | hit_rsv | hit_rw;

	// writable block locked after end of initialisation
	wire wr_cfg = wr & hit_cfg & unlocked;
	wire wr_axis = wr & hit_axis & unlocked;
	wire wr_arm = wr & hit_arm & unlocked;
	wire wr_pos = wr & hit_pos & unlocked;
	wire wr_neg = wr & hit_neg & unlocked;
	wire wr_ctl_low = wr & hit_ctl & unlocked;
	wire [5:0] next_ctl_low = {cmd.data[`CTL_OFFCFG_EN] ? cmd.data[5:4] : ctl_low[5:4],
		cmd.data[3:0]};

	wire [7:0] status_byte = {1'b0, CRC_ERR, 1'b0, ~READY, MISO_ERR, 1'b0, OFFSET_ERR, devres};

	// read selection; reserved and factory reads have no side effect
	wire [7:0] rdata =
		(cmd.addr == `OFS_UNIT_ID0) ? otp_shadow[47:40] :
		(cmd.addr == `OFS_UNIT_ID1) ? otp_shadow[55:48] :
		(cmd.addr == `OFS_UNIT_ID2) ? otp_shadow[63:56] :
		(cmd.addr == `OFS_UNIT_ID3) ? otp_shadow[71:64] :
		(cmd.addr == `OFS_SELF_TEST_DEFL) ? otp_shadow[39:32] :
		(cmd.addr == `OFS_RESERVED_05) ? otp_shadow[31:24] :
		(cmd.addr == `OFS_FACTORY_CONFIG) ? otp_shadow[23:16] :
		(cmd.addr == `OFS_PART_NUMBER) ? otp_shadow[15:8] :
		hit_ctl ? {2'b00, ctl_low} :
		hit_cfg ? device_config :
		hit_axis ? axis_config :
		hit_arm ? arming_config :
		hit_pos ? thr_pos :
		hit_neg ? thr_neg :
		hit_stat ? status_byte :
		(cmd.addr == `OFS_ARM_TALLY) ? ARM_TALLY :
		(cmd.addr == `OFS_OFFSET_CORR) ? OFFSET_CORR :
		(cmd.addr == `OFS_RESERVED_1C) ? otp_shadow[7:0] :
		(cmd.addr == `OFS_RESERVED_1D) ? trim_1d :
		`RST_REG8;

	// separate checkers for factory and writable blocks
	wire [7:0] otp_crc = crc8(otp_shadow);
	wire [7:0] trim_crc = crc8({FACTORY_TRIM_1D, 64'h0});
	wire [71:0] w_image = {24'h0, 2'b00, ctl_low, device_config, axis_config, arming_config,
		thr_pos, thr_neg};
	wire [7:0] w_crc = crc8(w_image);
	wire otp_err = (otp_crc != OTP_CRC_REF) | (crc8({trim_1d, 64'h0}) != trim_crc);
	// writable check only runs after end of initialisation
	wire w_err = wcrc_armed & (w_crc != wcrc_ref);

	// reset key sequence 00, 11, 01 on consecutive frames
	wire [1:0] key = {cmd.data[`CTL_KEY_HI], cmd.data[`CTL_KEY_LO]};
	wire key_write = wr & hit_ctl;
	wire key_fire = key_write & (key_state == KEY_SECOND) & (key == 2'b01);

	always_comb begin
		next_key_state = key_state;
		if (frame_done | frame_bad) begin
			case (key_state)
				KEY_IDLE: next_key_state = (key_write && key == 2'b00) ? KEY_FIRST : KEY_IDLE;
				KEY_FIRST: next_key_state = (key_write && key == 2'b11) ? KEY_SECOND :
					(key_write && key == 2'b00) ? KEY_FIRST : KEY_IDLE;
				KEY_SECOND: next_key_state = (key_write && key == 2'b00) ? KEY_FIRST : KEY_IDLE;
				default: next_key_state = KEY_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			key_state <= KEY_IDLE;
			soft_rst <= 1'b0;
		end else begin
			key_state <= soft_rst ? KEY_IDLE : next_key_state;
			// frame end seen 1-2 cycles after CS rises, reset one later: under 300 ns
			soft_rst <= frame_done & key_fire;
		end
	end

	// serial receive and transmit
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bit_cnt <= 5'h00;
			rx_shift <= 16'h0000;
		end else if (cs_fall) begin
			bit_cnt <= 5'h00;
		end else if (sclk_rise & cs_low) begin
			rx_shift <= {rx_shift[14:0], mosi_sync[1]};
			bit_cnt <= (bit_cnt == 5'h1F) ? bit_cnt : bit_cnt + 5'h01;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_shift <= 16'h0000;
		end else if (cs_fall) begin
			tx_shift <= resp;
		end else if (sclk_fall & cs_low) begin
			tx_shift <= {tx_shift[14:0], 1'b0};
		end
	end

	// answer to the frame just ended, sent in the next one
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			resp <= '0;
		end else if (soft_rst) begin
			resp <= '0;
		end else if (frame_done) begin
			resp.status <= hit_valid ? `RESP_OK : `RESP_INVALID;
			resp.addr <= cmd.addr;
			resp.data <= hit_valid ? rdata : `RST_REG8;
		end
	end

	// factory shadow and trim have no write path
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			otp_shadow <= OTP_IMAGE;
			trim_1d <= FACTORY_TRIM_1D;
		end else begin
			otp_shadow <= otp_shadow;
			trim_1d <= trim_1d;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctl_low <= `RST_CTL_LOW;
			device_config <= `RST_REG8;
			axis_config <= `RST_REG8;
		end else if (soft_rst) begin
			ctl_low <= `RST_CTL_LOW;
			device_config <= `RST_REG8;
			axis_config <= `RST_REG8;
		end else begin
			ctl_low <= wr_ctl_low ? next_ctl_low : ctl_low;
			device_config <= wr_cfg ? cmd.data : device_config;
			axis_config <= wr_axis ? cmd.data : axis_config;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			arming_config <= `RST_REG8;
			thr_pos <= `RST_REG8;
			thr_neg <= `RST_REG8;
		end else if (soft_rst) begin
			arming_config <= `RST_REG8;
			thr_pos <= `RST_REG8;
			thr_neg <= `RST_REG8;
		end else begin
			arming_config <= wr_arm ? cmd.data : arming_config;
			thr_pos <= wr_pos ? cmd.data : thr_pos;
			thr_neg <= wr_neg ? cmd.data : thr_neg;
		end
	end

	// reference taken the cycle after end of initialisation is set
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wcrc_ref <= `RST_CRC;
			wcrc_armed <= 1'b0;
		end else if (soft_rst) begin
			wcrc_ref <= `RST_CRC;
			wcrc_armed <= 1'b0;
		end else if (endinit & ~wcrc_armed) begin
			wcrc_ref <= w_crc;
			wcrc_armed <= 1'b1;
		end
	end

	// reset flag set by any reset, cleared by a status read
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			devres <= 1'b1;
		end else if (soft_rst) begin
			devres <= 1'b1;
		end else if (rd & hit_stat) begin
			devres <= 1'b0;
		end
	end

	// readiness counter; only power-on restarts it
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			por_cnt <= 20'h00000;
		end else if (por_cnt != 20'(POR_READY_CYCLES)) begin
			por_cnt <= por_cnt + 20'h00001;
		end
	end

	// divided test clock
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			test_cnt <= 8'h00;
			test_clk <= 1'b0;
		end else if (test_cnt == 8'(`TEST_HALF_CYCLES - 1)) begin
			test_cnt <= 8'h00;
			test_clk <= ~test_clk;
		end else begin
			test_cnt <= test_cnt + 8'h01;
		end
	end

	// identifier bytes drive no operating output
	assign CFG = '{device_config, axis_config, arming_config, thr_pos, thr_neg};
	assign CTL_LOW = ctl_low;
	// offset monitor forced on while offset-cancelled data is chosen
	assign OFFSET_MONITOR_EN = device_config[`CFG_OFMON] | ~device_config[`CFG_OC_N];
	// self test stops once normal operation starts, the bit itself is kept
	assign SELF_TEST_EN = axis_config[`AXIS_ST] & unlocked;
	assign CRC_ERR = otp_err | w_err;
	assign SOFT_RESET = soft_rst;
	assign READY = por_cnt == 20'(POR_READY_CYCLES);
	assign TEST_CLK = test_clk;
	assign MISO = tx_shift[15];
	assign MISO_OE = cs_low;

endmodule

// [sensor_cfg_chk.sv]
// Purpose: port assertions for the config array
// Assumes: serial pins change on the falling CLK edge
// Notes: bound to the array at the foot
module sensor_cfg_chk #(
	parameter int POR_READY_CYCLES = 16800
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CS_N,
	input wire sensor_cfg_pkg::cfg_t CFG,
	input wire logic [5:0] CTL_LOW,
	input wire logic SELF_TEST_EN,
	input wire logic CRC_ERR,
	input wire logic SOFT_RESET,
	input wire logic READY,
	input wire logic TEST_CLK
);
	import sensor_cfg_pkg::*;
	logic [15:0] up_cnt;
	logic [3:0] hi_cnt;
	// saturating, so long runs never wrap into a false early-ready
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			up_cnt <= 16'h0000;
			hi_cnt <= 4'h0;
		end else begin
			up_cnt <= up_cnt + {15'h0000, up_cnt != 16'hFFFF};
			hi_cnt <= CS_N ? hi_cnt + {3'h0, hi_cnt != 4'hF} : 4'h0;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_ready_early: assert property (up_cnt + 1 < POR_READY_CYCLES |-> !READY)
		else $error("ready too early");
	a_ready_late: assert property (up_cnt > POR_READY_CYCLES + 1 |-> READY)
		else $error("ready too late");
	a_reset_latency: assert property (SOFT_RESET |-> hi_cnt inside {[2:6]})
		else $error("soft reset outside window");
	a_reset_pulse: assert property (SOFT_RESET |=> !SOFT_RESET)
		else $error("soft reset longer than a cycle");
	a_reset_clears: assert property (SOFT_RESET |-> ##[0:2] (CFG == '0 && CTL_LOW == 6'h00))
		else $error("soft reset left registers");
	a_test_clk: assert property ($changed(TEST_CLK) |-> ##10 $changed(TEST_CLK))
		else $error("test clock half period wrong");
	a_lock_hold: assert property ($past(CFG.device_config[5]) && !$past(SOFT_RESET)
		&& !SOFT_RESET |-> $stable({CFG, CTL_LOW}))
		else $error("locked register changed");
	a_self_test: assert property (SELF_TEST_EN == (CFG.axis_config[7] && !CFG.device_config[5]))
		else $error("self test gate wrong");
	a_crc_clean: assert property (!CRC_ERR)
		else $error("crc flagged on clean array");
endmodule

bind sensor_config_data_array sensor_cfg_chk #(.POR_READY_CYCLES(POR_READY_CYCLES)) chk_u (
	.CLK(CLK),
	.RST(RST),
	.CS_N(CS_N),
	.CFG(CFG),
	.CTL_LOW(CTL_LOW),
	.SELF_TEST_EN(SELF_TEST_EN),
	.CRC_ERR(CRC_ERR),
	.SOFT_RESET(SOFT_RESET),
	.READY(READY),
	.TEST_CLK(TEST_CLK)
);

// [spi_host_model.sv]
// Purpose: serial host, mode 0, 16-bit frames
// Assumes: 400 ns serial clock, eight CLK periods
// Notes: serial clock idles low between frames
module spi_host_model (
	input wire logic clk,
	input wire logic miso,
	output logic cs_n,
	output logic sclk,
	output logic mosi
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		@(negedge clk) cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			repeat (4) @(negedge clk);
			// falling edge lets the device shift its next answer bit
			sclk = 1'b0;
			mosi = tx[i];
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			rx[i] = miso;
		end
		repeat (4) @(negedge clk);
		sclk = 1'b0;
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		// no pull on the line, so never leave the last bit standing
		mosi = ~mosi;
		repeat (6) @(negedge clk);
	endtask
endmodule

// [tb_sensor_config_data_array.sv]
// Purpose: self-checking bench for the config array
// Assumes: host model drives the serial pins
// Notes: short power-on count keeps the run brief
`include "sensor_cfg_consts.svh"
module tb_sensor_config_data_array;
	timeunit 1ns;
	timeprecision 1ns;
	import sensor_cfg_pkg::*;
	localparam logic [31:0] UID = {19'h2A5C3, 13'h1B7E};
	localparam logic [4:0] RO_A [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
		5'h08, 5'h15, 5'h16, 5'h1C, 5'h1D};
	localparam logic [7:0] RO_D [12] = '{UID[7:0], UID[15:8], UID[23:16], UID[31:24], 8'hC5,
		8'h3A, 8'h80, 8'h5E, 8'h3C, 8'hA7, 8'h91, 8'h6D};
	localparam logic [4:0] BAD [7] = '{5'h07, 5'h09, 5'h0D, 5'h0F, 5'h11, 5'h13, 5'h17};
	logic clk, rst, miso, miso_oe, miso_err, ofs_err, soft_rst, ready, test_clk, crc_err;
	logic ofmon_en, st_en;
	logic [5:0] ctl_low;
	logic [7:0] arm_tally, ofs_corr;
	logic [15:0] rsp;
	cfg_t cfg;
	wire cs_n, sclk, mosi;
	wire miso_w = miso_oe ? miso : 1'bz;
	int failures = 0;
	int checks_done = 0;
	int n_sr = 0;
	sensor_config_data_array #(
		.LOT_NUMBER(UID[31:13]), .SERIAL_NUMBER(UID[12:0]), .SELF_TEST_DEFL(RO_D[4]),
		.FACTORY_TRIM_05(RO_D[5]), .SELF_TEST_MAG(RO_D[6][7]), .PART_NUMBER(RO_D[7]),
		.FACTORY_TRIM_1C(RO_D[10]), .FACTORY_TRIM_1D(RO_D[11]), .POR_READY_CYCLES(50)
	) dut_u (
		.CLK(clk),
		.RST(rst),
		.CS_N(cs_n),
		.SCLK(sclk),
		.MOSI(mosi),
		.MISO(miso),
		.MISO_OE(miso_oe),
		.ARM_TALLY(arm_tally),
		.OFFSET_CORR(ofs_corr),
		.MISO_ERR(miso_err),
		.OFFSET_ERR(ofs_err),
		.CFG(cfg),
		.CTL_LOW(ctl_low),
		.OFFSET_MONITOR_EN(ofmon_en),
		.SELF_TEST_EN(st_en),
		.CRC_ERR(crc_err),
		.SOFT_RESET(soft_rst),
		.READY(ready),
		.TEST_CLK(test_clk)
	);
	spi_host_model host_u (.clk(clk), .miso(miso_w), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (soft_rst === 1'b1) n_sr++;
	end
	task automatic complete_run();
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [39:0] seen, logic [39:0] ex);
		checks_done++;
		if (seen !== ex) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic xf(logic w, logic [4:0] a, logic [7:0] d);
		host_u.xfer({w, 2'b00, a, d}, rsp);
	endtask
	// answer arrives one frame late, so a harmless read fetches it
	task automatic rd(logic [4:0] a, logic [2:0] st, logic [7:0] ex);
		xf(1'b0, a, 8'h00);
		xf(1'b0, `OFS_SELF_TEST_DEFL, 8'h00);
		chk("read", 40'(rsp), 40'({st, a, ex}));
	endtask
	initial begin
		repeat (60000) @(negedge clk);
		failures++;
		complete_run();
	end
	initial begin
		rst = 1'b1;
		miso_err = 1'b1;
		ofs_err = 1'b1;
		arm_tally = 8'h3C;
		ofs_corr = 8'hA7;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge clk);
		chk("ready", 40'(ready), 40'h1);
		if (ready !== 1'b1) complete_run();
		rd(`OFS_DEVICE_STATUS, `RESP_OK, 8'h0B);
		miso_err = 1'b0;
		ofs_err = 1'b0;
		rd(`OFS_DEVICE_STATUS, `RESP_OK, 8'h00);
		foreach (RO_A[i]) begin
			xf(1'b1, RO_A[i], ~RO_D[i]);
			rd(RO_A[i], `RESP_OK, RO_D[i]);
		end
		// live inputs must show through, not a latched copy
		arm_tally = 8'h5A;
		ofs_corr = 8'hC3;
		rd(`OFS_ARM_TALLY, `RESP_OK, 8'h5A);
		rd(`OFS_OFFSET_CORR, `RESP_OK, 8'hC3);
		foreach (BAD[i]) begin
			xf(1'b1, BAD[i], 8'hFF);
			rd(BAD[i], `RESP_INVALID, 8'h00);
		end
		xf(1'b1, `OFS_DEVICE_CONFIG, 8'h97);
		xf(1'b1, `OFS_AXIS_CONFIG, 8'h8C);
		xf(1'b1, `OFS_ARMING_CONFIG, 8'h3C);
		xf(1'b1, `OFS_ARM_THR_POS, 8'hE1);
		xf(1'b1, `OFS_ARM_THR_NEG, 8'h1E);
		xf(1'b1, `OFS_DEVICE_CONTROL, 8'h38);
		chk("cfg", cfg, 40'h978C3CE11E);
		chk("selftest", 40'(st_en), 40'h1);
		chk("ofmon", 40'(ofmon_en), 40'h0);
		rd(`OFS_DEVICE_CONTROL, `RESP_OK, 8'h38);
		xf(1'b1, `OFS_DEVICE_CONTROL, 8'h38);
		xf(1'b1, `OFS_DEVICE_CONTROL, 8'hF8);
		xf(1'b0, `OFS_DEVICE_CONFIG, 8'h00);
		xf(1'b1, `OFS_DEVICE_CONTROL, 8'h78);
		chk("abort", 40'(n_sr), 40'h0);
		xf(1'b1, `OFS_DEVICE_CONFIG, 8'h20);
		xf(1'b1, `OFS_AXIS_CONFIG, 8'h00);
		xf(1'b1, `OFS_DEVICE_CONFIG, 8'h00);
		chk("locked", cfg, 40'h208C3CE11E);
		chk("selftest", 40'(st_en), 40'h0);
		xf(1'b1, `OFS_DEVICE_CONTROL, 8'h00);
		chk("ctl", 40'(ctl_low), 40'h38);
		xf(1'b1, `OFS_DEVICE_CONTROL, 8'hC0);
		xf(1'b1, `OFS_DEVICE_CONTROL, 8'h40);
		chk("resets", 40'(n_sr), 40'h1);
		chk("cleared", cfg, 40'h0);
		chk("ctlclr", 40'(ctl_low), 40'h0);
		chk("ofmon", 40'(ofmon_en), 40'h1);
		rd(`OFS_DEVICE_STATUS, `RESP_OK, 8'h01);
		xf(1'b1, `OFS_DEVICE_CONFIG, 8'h04);
		rd(`OFS_DEVICE_CONFIG, `RESP_OK, 8'h04);
		chk("crc", 40'(crc_err), 40'h0);
		complete_run();
	end
endmodule
